// file: shared/mtsr_pkg.sv
// mtsr_pkg: register map, field positions and reset values shared by the
// transmit status / receive control block.
// assumes a 32-bit classic wishbone slave, one register per aligned word.
package mtsr_pkg;

   // -----------------------------------------------------------------
   // register word indices; byte address is index times four
   // -----------------------------------------------------------------
   localparam logic [7:0] TX_STATUS_IDX  = 8'h72; // printed offset
   localparam logic [7:0] RX_CTRL1_IDX   = 8'h74;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'h80; // extra registers
   localparam logic [7:0] IRQ_MASK_IDX   = 8'h81;
   localparam logic [7:0] LINK_CTRL_IDX  = 8'h82;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int LATE_COLL_BIT  = 13;
   localparam int EXCESS_COLL_BIT = 12;
   localparam int TAG_MSB        = 5;
   localparam int FLUSH_BIT      = 15;
   localparam int UDP_CHK_BIT    = 14;
   localparam int TCP_CHK_BIT    = 13;
   localparam int IP_CHK_BIT     = 12;
   localparam int UNICAST_BIT    = 11;
   localparam int PAUSE_BIT      = 10;
   localparam int CRC_ACC_BIT    = 9;
   localparam int MULTICAST_BIT  = 8;
   localparam int RUN_BIT        = 0;
   localparam int CTRL_HI_LSB    = 8;

   // interrupt status bits
   localparam int IRQ_TX_DONE   = 0;
   localparam int IRQ_RX_DROP   = 1;
   localparam int IRQ_RX_ACCEPT = 2;
   localparam int IRQ_W         = 3;

   // -----------------------------------------------------------------
   // reset values and control write mask
   // -----------------------------------------------------------------
   localparam logic [15:0] RX_CTRL1_RESET  = 16'h0800;
   localparam logic [15:0] TX_STATUS_RESET = 16'h0000;
   localparam logic [15:0] CTRL1_WMASK     = 16'hff01;

   // receive states
   typedef enum logic [2:0] {
      MTSR_IDLE  = 3'b001,
      MTSR_FRAME = 3'b010,
      MTSR_FLUSH = 3'b100
   } mtsr_rx_state_t;

endpackage

// file: hw/mtsr_top.sv
// mtsr_top: last-frame transmit status word, upper receive control word,
// frame accept/drop decision, pause gating and an interrupt block.
// assumes the transmit engine, receive parser and pause timer live outside
// and report frame outcomes as one-cycle pulses on CLK_SYS.
//
// How it works
// - transmit status word is read only and describes the last sent frame.
// - bit 13 shows a late collision of that frame.
// - bit 12 shows the frame hit the maximum collision count.
// - bits 5..0 hold that frame's tag; all fields describe that frame.
// - while flush bit 15 is set, queue memory clears, frame pointer resets.
// - bit 14 enables udp checksum check; bad udp frames are dropped.
// - bit 13 enables tcp checksum check; bad tcp frames are dropped.
// - bit 12 enables ip header check; bad ip frames are dropped.
// - bit 11, reset one, accepts unicast frames passing the address filter.
// - full duplex and bit 10 hold transmit while pause timer runs.
// - bit 9 admits crc error frames; clear drops all of them.
// - bit 8 accepts multicast frames passing the address filter.
// - bit 0 starts reception; clearing stops after the current frame.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module mtsr_top
   import mtsr_pkg::*;
#(
   parameter int TAG_W = 6
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RESET_N,
   // wishbone slave
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [9:0]        WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic      [31:0]       WB_DAT_O,
   output logic                   WB_ACK_O,
   output logic                   WB_ERR_O,
   // transmit engine report
   input  wire logic              TX_DONE,
   input  wire logic              TX_LATE_COLL,
   input  wire logic              TX_EXCESS_COLL,
   input  wire logic [TAG_W-1:0]  TX_TAG,
   // receive parser verdict, valid with RX_END
   input  wire logic              RX_START,
   input  wire logic              RX_END,
   input  wire logic              RX_IS_UDP,
   input  wire logic              RX_IS_TCP,
   input  wire logic              RX_IS_IP,
   input  wire logic              RX_UDP_BAD,
   input  wire logic              RX_TCP_BAD,
   input  wire logic              RX_IP_BAD,
   input  wire logic              RX_CRC_BAD,
   input  wire logic              RX_UNICAST_HIT,
   input  wire logic              RX_MULTICAST_HIT,
   // pause timer state and duplex from the phy side
   input  wire logic              PAUSE_ACTIVE,
   input  wire logic              FULL_DUPLEX,
   // outputs to datapath
   output logic                   RX_ACCEPT,
   output logic                   RX_DROP,
   output logic                   RX_RUNNING,
   output logic                   RXQ_CLEAR,
   output logic                   TX_HOLD,
   output logic                   IRQ
);

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_n;

   // release in two stages so every flop leaves reset on the same edge
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // -----------------------------------------------------------------
   // duplex pin synchroniser
   // -----------------------------------------------------------------
   logic [2:0] dup_sync_q;
   logic       full_dup_q;

   // third stage must agree with second before the level is believed
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         dup_sync_q <= 3'h0;
         full_dup_q <= 1'b0;
      end else begin
         dup_sync_q <= {dup_sync_q[1:0], FULL_DUPLEX};
         if (dup_sync_q[2] == dup_sync_q[1]) begin
            full_dup_q <= dup_sync_q[2];
         end
      end
   end

   // -----------------------------------------------------------------
   // registers and bus decode
   // -----------------------------------------------------------------
   logic [15:0]        tx_status_q;
   logic [15:0]        ctrl1_q;
   logic [IRQ_W-1:0]   irq_stat_q;
   logic [IRQ_W-1:0]   irq_mask_q;
   logic [IRQ_W-1:0]   irq_set;
   logic               bus_req;
   logic               hit_ctrl;
   logic               hit_stat;
   logic               hit_mask;
   logic               hit_tx;
   logic               mapped;
   logic [7:0]         word_idx;

   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  sel);
      lane_merge = old;
      if (sel[0]) lane_merge[7:0] = data[7:0];
      if (sel[1]) lane_merge[15:8] = data[15:8];
   endfunction

   assign word_idx = WB_ADR_I[9:2];
   assign bus_req  = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
   assign hit_tx   = (word_idx == TX_STATUS_IDX);
   assign hit_ctrl = (word_idx == RX_CTRL1_IDX);
   assign hit_stat = (word_idx == IRQ_STATUS_IDX);
   assign hit_mask = (word_idx == IRQ_MASK_IDX);
   assign mapped   = hit_tx || hit_ctrl || hit_stat || hit_mask;

   // one-cycle answer; unmapped words get err so software sees the slip
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         WB_ACK_O <= 1'b0;
         WB_ERR_O <= 1'b0;
         WB_DAT_O <= 32'h0;
      end else begin
         WB_ACK_O <= bus_req && mapped;
         WB_ERR_O <= bus_req && !mapped;
         WB_DAT_O <= 32'h0;
         if (bus_req && !WB_WE_I) begin
            if (hit_tx) WB_DAT_O <= {16'h0, tx_status_q};
            if (hit_ctrl) WB_DAT_O <= {16'h0, ctrl1_q};
            if (hit_stat) WB_DAT_O <= {29'h0, irq_stat_q};
            if (hit_mask) WB_DAT_O <= {29'h0, irq_mask_q};
         end
      end
   end

   // receive control word; lower bits other than run are not kept here
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1_q <= RX_CTRL1_RESET;
      end else if (bus_req && WB_WE_I && hit_ctrl) begin
         ctrl1_q <= lane_merge(ctrl1_q, WB_DAT_I, WB_SEL_I) & CTRL1_WMASK;
      end
   end

   // -----------------------------------------------------------------
   // transmit status capture
   // -----------------------------------------------------------------
   // one write of the whole word so a read never mixes two frames
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         tx_status_q <= TX_STATUS_RESET;
      end else if (TX_DONE) begin
         tx_status_q <= 16'h0;
         tx_status_q[LATE_COLL_BIT] <= TX_LATE_COLL;
         tx_status_q[EXCESS_COLL_BIT] <= TX_EXCESS_COLL;
         tx_status_q[TAG_MSB:0] <= TX_TAG[TAG_MSB:0];
      end
   end

   // -----------------------------------------------------------------
   // receive run / flush state machine
   // -----------------------------------------------------------------
   mtsr_rx_state_t rx_state_q;
   logic           run_en;
   logic           flush_en;
   logic           verdict_ok;

   assign run_en   = ctrl1_q[RUN_BIT];
   assign flush_en = ctrl1_q[FLUSH_BIT];

   // a frame in flight finishes even if run is cleared meanwhile
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_q <= MTSR_IDLE;
      end else begin
         unique case (rx_state_q)
            MTSR_IDLE: begin
               if (flush_en) begin
                  rx_state_q <= MTSR_FLUSH;
               end else if (run_en && RX_START) begin
                  rx_state_q <= MTSR_FRAME;
               end
            end
            MTSR_FRAME: begin
               if (RX_END) begin
                  rx_state_q <= MTSR_IDLE;
               end
            end
            MTSR_FLUSH: begin
               // software clears run first, then flush to resume
               if (!flush_en) begin
                  rx_state_q <= MTSR_IDLE;
               end
            end
            default: rx_state_q <= MTSR_IDLE;
         endcase
      end
   end

   // frame verdict from the enabled checks and filters
   always_comb begin
      verdict_ok = 1'b1;
      if (ctrl1_q[UDP_CHK_BIT] && RX_IS_UDP && RX_UDP_BAD) begin
         verdict_ok = 1'b0;
      end
      if (ctrl1_q[TCP_CHK_BIT] && RX_IS_TCP && RX_TCP_BAD) begin
         verdict_ok = 1'b0;
      end
      if (ctrl1_q[IP_CHK_BIT] && RX_IS_IP && RX_IP_BAD) begin
         verdict_ok = 1'b0;
      end
      if (!ctrl1_q[CRC_ACC_BIT] && RX_CRC_BAD) begin
         verdict_ok = 1'b0;
      end
      if (!((ctrl1_q[UNICAST_BIT] && RX_UNICAST_HIT) ||
            (ctrl1_q[MULTICAST_BIT] && RX_MULTICAST_HIT))) begin
         verdict_ok = 1'b0;
      end
   end

   // verdict pulses, one per finished frame
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         RX_ACCEPT  <= 1'b0;
         RX_DROP    <= 1'b0;
         RX_RUNNING <= 1'b0;
         RXQ_CLEAR  <= 1'b0;
      end else begin
         RX_ACCEPT  <= (rx_state_q == MTSR_FRAME) && RX_END && verdict_ok;
         RX_DROP    <= (rx_state_q == MTSR_FRAME) && RX_END && !verdict_ok;
         RX_RUNNING <= run_en || (rx_state_q == MTSR_FRAME);
         RXQ_CLEAR  <= flush_en;
      end
   end

   // -----------------------------------------------------------------
   // pause gating
   // -----------------------------------------------------------------
   // half duplex ignores the enable bit entirely
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         TX_HOLD <= 1'b0;
      end else begin
         TX_HOLD <= full_dup_q && ctrl1_q[PAUSE_BIT] && PAUSE_ACTIVE;
      end
   end

   // -----------------------------------------------------------------
   // interrupts
   // -----------------------------------------------------------------
   assign irq_set = {RX_ACCEPT, RX_DROP, TX_DONE};

   // write one clears; a same-cycle event wins over the clear
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
      end else begin
         if (bus_req && WB_WE_I && hit_stat && WB_SEL_I[0]) begin
            irq_stat_q <= (irq_stat_q & ~WB_DAT_I[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         if (bus_req && WB_WE_I && hit_mask && WB_SEL_I[0]) begin
            irq_mask_q <= WB_DAT_I[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_q & irq_mask_q);
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_status_capture: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      TX_DONE |=> tx_status_q == {2'b00, $past(TX_LATE_COLL),
         $past(TX_EXCESS_COLL), 6'h00, $past(TX_TAG)})
      else $error("tx status word not captured whole");
   a_status_hold: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      !TX_DONE |=> $stable(tx_status_q))
      else $error("tx status changed without a frame");
   a_late_flag: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      TX_DONE && TX_LATE_COLL |=> tx_status_q[LATE_COLL_BIT])
      else $error("late collision flag missing");
   a_excess_flag: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      TX_DONE |=> tx_status_q[EXCESS_COLL_BIT] == $past(TX_EXCESS_COLL))
      else $error("excess collision flag wrong");
   a_flush_clear: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      flush_en |=> RXQ_CLEAR)
      else $error("flush did not clear queue");
   a_udp_drop: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      rx_state_q == MTSR_FRAME && RX_END && ctrl1_q[UDP_CHK_BIT]
      && RX_IS_UDP && RX_UDP_BAD |=> RX_DROP && !RX_ACCEPT)
      else $error("bad udp frame not dropped");
   a_tcp_drop: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      rx_state_q == MTSR_FRAME && RX_END && ctrl1_q[TCP_CHK_BIT]
      && RX_IS_TCP && RX_TCP_BAD |=> RX_DROP)
      else $error("bad tcp frame not dropped");
   a_ip_drop: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      rx_state_q == MTSR_FRAME && RX_END && ctrl1_q[IP_CHK_BIT]
      && RX_IS_IP && RX_IP_BAD |=> RX_DROP)
      else $error("bad ip frame not dropped");
   a_crc_drop: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      rx_state_q == MTSR_FRAME && RX_END && !ctrl1_q[CRC_ACC_BIT]
      && RX_CRC_BAD |=> !RX_ACCEPT)
      else $error("crc error frame accepted");
   a_filter_need: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      RX_ACCEPT |-> ($past(ctrl1_q[UNICAST_BIT]) && $past(RX_UNICAST_HIT)
      || $past(ctrl1_q[MULTICAST_BIT]) && $past(RX_MULTICAST_HIT)))
      else $error("frame accepted without filter hit");
   a_multi_ok: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      rx_state_q == MTSR_FRAME && RX_END && ctrl1_q[MULTICAST_BIT]
      && RX_MULTICAST_HIT && !RX_CRC_BAD
      && ctrl1_q[UDP_CHK_BIT:IP_CHK_BIT] == 3'h0 |=> RX_ACCEPT)
      else $error("multicast hit not accepted");
   a_pause_hold: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      TX_HOLD |-> $past(full_dup_q) && $past(ctrl1_q[PAUSE_BIT])
      && $past(PAUSE_ACTIVE))
      else $error("transmit held without pause");
   a_run_finish: assert property (
      @(posedge CLK_SYS) disable iff (!rst_n)
      rx_state_q == MTSR_FRAME && !RX_END |=> rx_state_q == MTSR_FRAME)
      else $error("frame in progress cut short");

endmodule

// file: tb/mtsr_link_model.sv
// mtsr_link_model: stands in for the transmit engine, receive parser and phy
// on the far side of mtsr_top.
// assumes every task is entered right after a rising edge of clk.
`timescale 1ns/1ps
module mtsr_link_model (
   input  wire logic       clk,
   input  wire logic       rx_accept,
   input  wire logic       rx_drop,
   output logic            tx_done,
   output logic            tx_late,
   output logic            tx_excess,
   output logic [5:0]      tx_tag,
   output logic            rx_start,
   output logic            rx_end,
   output logic [8:0]      rx_flags,
   output logic            pause_active,
   output logic            full_duplex
);
   // ---------------------------------------------------------------
   // idle levels
   // ---------------------------------------------------------------
   initial begin
      tx_done      = 1'b0;
      tx_late      = 1'b0;
      tx_excess    = 1'b0;
      tx_tag       = 6'h00;
      rx_start     = 1'b0;
      rx_end       = 1'b0;
      rx_flags     = 9'h000;
      pause_active = 1'b0;
      full_duplex  = 1'b0;
   end

   // one report per call; consecutive calls give back-to-back pulses
   task automatic tx_pulse(input logic l, input logic e, input logic [5:0] t);
      tx_done   <= 1'b1;
      tx_late   <= l;
      tx_excess <= e;
      tx_tag    <= t;
      @(posedge clk);
   endtask

   // fields go stale after the pulse so a late sample cannot pass
   task automatic tx_end();
      tx_done   <= 1'b0;
      tx_late   <= ~tx_late;
      tx_excess <= ~tx_excess;
      tx_tag    <= ~tx_tag;
   endtask

   // start pulse alone, so the bench can act while the frame is open
   task automatic rx_open();
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
   endtask

   // end with verdict levels, then sample the registered answer
   task automatic rx_close(input logic [8:0] f, output logic a,
                           output logic d);
      rx_end   <= 1'b1;
      rx_flags <= f;
      @(posedge clk);
      rx_end   <= 1'b0;
      rx_flags <= ~f;
      @(posedge clk);
      a = rx_accept;
      d = rx_drop;
   endtask

   task automatic rx_frame(input logic [8:0] f, output logic a,
                           output logic d);
      rx_open();
      rx_close(f, a, d);
   endtask

   task automatic link(input logic fd, input logic pa);
      full_duplex  <= fd;
      pause_active <= pa;
   endtask
endmodule

// file: tb/tb_mtsr_top.sv
// tb_mtsr_top: register and frame-verdict checks for mtsr_top.
// assumes mtsr_link_model drives every far-side input.
`timescale 1ns/1ps
module tb_mtsr_top;
   import mtsr_pkg::*;
   localparam logic [9:0] TX_A = 10'h1c8;
   localparam logic [9:0] RX_A = 10'h1d0;
   localparam logic [9:0] ST_A = 10'h200;
   localparam logic [9:0] MK_A = 10'h204;
   localparam logic [9:0] NO_A = 10'h3fc;
   logic        clk_sys, reset_n, cyc, stb, we, ack, err, irq;
   logic        tx_done, tx_late, tx_exc, rx_start, rx_end, pause, fdx;
   logic        rx_acc, rx_drp, rx_run, rxq_clr, tx_hold, a, d;
   logic [9:0]  adr;
   logic [31:0] wdat, rdat, rdata;
   logic [5:0]  tx_tag;
   logic [8:0]  fl;
   logic        rerr;
   int          failures, checks_done, cycles;

   mtsr_top u_mtsr_top (.CLK_SYS(clk_sys), .RESET_N(reset_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .WB_ERR_O(err), .TX_DONE(tx_done), .TX_LATE_COLL(tx_late),
      .TX_EXCESS_COLL(tx_exc), .TX_TAG(tx_tag), .RX_START(rx_start),
      .RX_END(rx_end), .RX_IS_UDP(fl[8]), .RX_IS_TCP(fl[7]),
      .RX_IS_IP(fl[6]), .RX_UDP_BAD(fl[5]), .RX_TCP_BAD(fl[4]),
      .RX_IP_BAD(fl[3]), .RX_CRC_BAD(fl[2]), .RX_UNICAST_HIT(fl[1]),
      .RX_MULTICAST_HIT(fl[0]), .PAUSE_ACTIVE(pause), .FULL_DUPLEX(fdx),
      .RX_ACCEPT(rx_acc), .RX_DROP(rx_drp), .RX_RUNNING(rx_run),
      .RXQ_CLEAR(rxq_clr), .TX_HOLD(tx_hold), .IRQ(irq));

   mtsr_link_model u_mtsr_link_model (.clk(clk_sys), .rx_accept(rx_acc),
      .rx_drop(rx_drp), .tx_done(tx_done), .tx_late(tx_late),
      .tx_excess(tx_exc), .tx_tag(tx_tag), .rx_start(rx_start),
      .rx_end(rx_end), .rx_flags(fl), .pause_active(pause),
      .full_duplex(fdx));

   // ---------------------------------------------------------------
   // clock, timeout and verdict
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // the sequence needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         conclude();
      end
   end

   task automatic conclude();
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ---------------------------------------------------------------
   // classic wishbone single cycle; ends one idle cycle after ack
   // ---------------------------------------------------------------
   task automatic wb(input logic w, input logic [9:0] ad, input logic [15:0] dt);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= ad;
      wdat <= {16'h0000, dt};
      @(posedge clk_sys);
      while (ack !== 1'b1 && err !== 1'b1) begin
         @(posedge clk_sys);
      end
      rdata = rdat;
      rerr  = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_sys);
   endtask

   // program the control word, run one frame, expect one verdict
   task automatic rx_case(input logic [15:0] c, input logic [8:0] f,
                          input logic [1:0] exp);
      wb(1'b1, RX_A, c);
      u_mtsr_link_model.rx_frame(f, a, d);
      chk({30'h0, a, d}, {30'h0, exp});
   endtask

   initial begin
      reset_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      wdat = 32'h0;
      failures = 0;
      checks_done = 0;
      cycles = 0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // reset values, read-only status, unmapped word
      wb(1'b0, RX_A, 16'h0); chk(rdata, 32'h0800);
      wb(1'b1, TX_A, 16'hffff);
      wb(1'b0, TX_A, 16'h0); chk(rdata, 32'h0000);
      wb(1'b0, NO_A, 16'h0); chk({31'h0, rerr}, 32'h1);
      wb(1'b1, RX_A, 16'h7ffe);
      wb(1'b0, RX_A, 16'h0); chk(rdata, 32'h7f00);
      // back-to-back reports: the later frame wins whole
      u_mtsr_link_model.tx_pulse(1'b1, 1'b0, 6'h2a);
      u_mtsr_link_model.tx_pulse(1'b0, 1'b1, 6'h15);
      u_mtsr_link_model.tx_end();
      wb(1'b0, TX_A, 16'h0); chk(rdata, 32'h1015);
      u_mtsr_link_model.tx_pulse(1'b1, 1'b0, 6'h3f);
      u_mtsr_link_model.tx_end();
      wb(1'b0, TX_A, 16'h0); chk(rdata, 32'h203f);
      // interrupt raised, masked, unmasked, cleared
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, MK_A, 16'h0001); chk({31'h0, irq}, 32'h1);
      wb(1'b1, ST_A, 16'h0001); chk({31'h0, irq}, 32'h0);
      wb(1'b0, ST_A, 16'h0); chk(rdata, 32'h0);
      // verdicts: {accept, drop}
      rx_case(16'h0801, 9'h002, 2'b10);
      rx_case(16'h0001, 9'h002, 2'b01);
      rx_case(16'h0101, 9'h001, 2'b10);
      rx_case(16'h0801, 9'h001, 2'b01);
      rx_case(16'h4801, 9'h122, 2'b01);
      rx_case(16'h0801, 9'h122, 2'b10);
      rx_case(16'h2801, 9'h092, 2'b01);
      rx_case(16'h1801, 9'h04a, 2'b01);
      rx_case(16'h0801, 9'h04a, 2'b10);
      rx_case(16'h0801, 9'h006, 2'b01);
      rx_case(16'h0a01, 9'h006, 2'b10);
      chk({31'h0, rx_run}, 32'h1);
      // run cleared mid-frame: the open frame still gets its verdict
      u_mtsr_link_model.rx_open();
      wb(1'b1, RX_A, 16'h0800);
      chk({31'h0, rx_run}, 32'h1);
      u_mtsr_link_model.rx_close(9'h002, a, d);
      chk({30'h0, a, d}, 32'h2);
      rx_case(16'h0800, 9'h002, 2'b00);
      chk({31'h0, rx_run}, 32'h0);
      // verdict events are sticky but masked off the irq pin
      wb(1'b0, ST_A, 16'h0); chk(rdata, 32'h6);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, ST_A, 16'h0006);
      wb(1'b0, ST_A, 16'h0); chk(rdata, 32'h0);
      // flush with reception stopped first, then resume
      wb(1'b1, RX_A, 16'h8800); chk({31'h0, rxq_clr}, 32'h1);
      wb(1'b1, RX_A, 16'h0800); chk({31'h0, rxq_clr}, 32'h0);
      rx_case(16'h0801, 9'h002, 2'b10);
      // pause only holds in full duplex with the enable set
      u_mtsr_link_model.link(1'b1, 1'b1);
      wb(1'b1, RX_A, 16'h0c01);
      repeat (6) @(posedge clk_sys);
      chk({31'h0, tx_hold}, 32'h1);
      u_mtsr_link_model.link(1'b1, 1'b0);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, tx_hold}, 32'h0);
      // full duplex and pause running with the enable bit clear, then half duplex with it set
      wb(1'b1, RX_A, 16'h0801);
      u_mtsr_link_model.link(1'b1, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, tx_hold}, 32'h0);
      wb(1'b1, RX_A, 16'h0c01);
      u_mtsr_link_model.link(1'b0, 1'b1);
      repeat (6) @(posedge clk_sys);
      chk({31'h0, tx_hold}, 32'h0);
      wb(1'b1, RX_A, 16'h0801);
      conclude();
   end
endmodule
